// ===== logic/mshe_status.sv
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "mshe_defines.svh"

module mshe_status (
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  input  wire logic                   mac_busy_i,
  input  wire mshe_pkg::mshe_tx_desc_s tx_desc_i,
  input  wire mshe_pkg::mshe_rx_desc_s rx_desc_i,
  input  wire mshe_pkg::mshe_apb_req_s apb_req_i,
  output mshe_pkg::mshe_apb_rsp_s      apb_rsp_o,
  output logic                        irq_o,
  output logic                        dma_halt_o
);
  import mshe_pkg::*;

  // Whole state of the register bank
  typedef struct packed {
    logic          idle;
    logic [1:0]    int_status;
    logic [1:0]    int_mask;
    logic          irq;
    logic          halt;
    logic          tx_stale;
    logic          rx_stale;
    mshe_apb_rsp_s rsp;
  } mshe_state_s;

  mshe_state_s st;
  mshe_state_s next_st;

  logic        tx_detect;
  logic        rx_detect;
  logic        tx_clr_ch;
  logic        rx_clr_ch;
  mshe_err_s   tx_err;
  mshe_err_s   rx_err;
  logic        setup;
  logic        done;
  logic        rd_done;
  logic        wr_done;
  logic        mapped;
  logic        rd_status;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic [1:0]  int_set;
  logic [1:0]  int_clr;

  // Transmit descriptor error capture
  mshe_tx_capture u_tx (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .desc_i    (tx_desc_i),
    .clr_ch_i  (tx_clr_ch),
    .detect_o  (tx_detect),
    .err_o     (tx_err)
  );

  // Receive descriptor error capture
  mshe_rx_capture u_rx (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .desc_i    (rx_desc_i),
    .clr_ch_i  (rx_clr_ch),
    .detect_o  (rx_detect),
    .err_o     (rx_err)
  );

  // APB phase decode
  always_comb begin
    setup   = apb_req_i.psel && !apb_req_i.penable;
    done    = apb_req_i.psel && apb_req_i.penable && st.rsp.pready;
    rd_done = done && !apb_req_i.pwrite;
    wr_done = done && apb_req_i.pwrite;
    rd_status = apb_req_i.paddr == `MSHE_ADDR_STATUS;
    mapped  = rd_status ||
              (apb_req_i.paddr == `MSHE_ADDR_INT_STATUS) ||
              (apb_req_i.paddr == `MSHE_ADDR_INT_MASK) ||
              (apb_req_i.paddr == `MSHE_ADDR_HALT);
  end

  // Status word assembly; reserved bits stay zero
  always_comb begin
    status_word = `MSHE_RST_WORD;
    status_word[`MSHE_IDLE_BIT] = st.idle;
    status_word[`MSHE_TX_CODE_LSB +: 4] = tx_err.code;
    status_word[`MSHE_TX_CH_LSB +: 3]   = tx_err.channel;
    status_word[`MSHE_RX_CODE_LSB +: 4] = rx_err.code;
    status_word[`MSHE_RX_CH_LSB +: 3]   = rx_err.channel;
  end

  // Read mux for the setup cycle
  always_comb begin
    rd_word = `MSHE_RST_WORD;
    case (apb_req_i.paddr)
      `MSHE_ADDR_STATUS: begin
        rd_word = status_word;
      end
      `MSHE_ADDR_INT_STATUS: begin
        rd_word[1:0] = st.int_status;
      end
      `MSHE_ADDR_INT_MASK: begin
        rd_word[1:0] = st.int_mask;
      end
      `MSHE_ADDR_HALT: begin
        rd_word[0] = st.halt;
      end
      default: begin
        rd_word = `MSHE_RST_WORD;
      end
    endcase
  end

  // Read of the status word clears channels, unless captured after snapshot
  always_comb begin
    tx_clr_ch = rd_done && rd_status && !st.tx_stale;
    rx_clr_ch = rd_done && rd_status && !st.rx_stale;
  end

  // Interrupt event and write-one-to-clear terms
  always_comb begin
    int_set = 2'h0;
    int_set[`MSHE_INT_TX_BIT] = tx_detect;
    int_set[`MSHE_INT_RX_BIT] = rx_detect;
    int_clr = 2'h0;
    if (wr_done && apb_req_i.paddr == `MSHE_ADDR_INT_STATUS) begin
      int_clr = apb_req_i.pwdata[1:0];
    end
  end

  // Next state
  always_comb begin
    next_st = st;
    // Idle follows the MAC activity one cycle late
    next_st.idle = !mac_busy_i;
    // Sticky status; an event beats a clear in the same cycle
    next_st.int_status = (st.int_status & ~int_clr) | int_set;
    if (wr_done && apb_req_i.paddr == `MSHE_ADDR_INT_MASK) begin
      next_st.int_mask = apb_req_i.pwdata[1:0];
    end
    next_st.irq = |(next_st.int_status & next_st.int_mask);
    // Halt latches on any host error; no write releases it
    if (tx_detect || rx_detect) begin
      next_st.halt = 1'b1;
    end
    // A capture between snapshot and completion keeps its channel
    if (setup) begin
      next_st.tx_stale = tx_detect;
      next_st.rx_stale = rx_detect;
    end else if (done) begin
      next_st.tx_stale = 1'b0;
      next_st.rx_stale = 1'b0;
    end
    // Answer in the first access cycle
    next_st.rsp.pready  = setup;
    next_st.rsp.pslverr = setup && !mapped;
    if (setup && !apb_req_i.pwrite) begin
      next_st.rsp.prdata = rd_word;
    end else if (done) begin
      next_st.rsp.prdata = `MSHE_RST_WORD;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st.idle       <= 1'b0;
      st.int_status <= `MSHE_RST_INT;
      st.int_mask   <= `MSHE_RST_INT;
      st.irq        <= 1'b0;
      st.halt       <= 1'b0;
      st.tx_stale   <= 1'b0;
      st.rx_stale   <= 1'b0;
      st.rsp        <= '{1'b0, 1'b0, `MSHE_RST_WORD};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign apb_rsp_o  = st.rsp;
  assign irq_o      = st.irq;
  assign dma_halt_o = st.halt;

endmodule : mshe_status

// ===== logic/mshe_defines.svh
`ifndef MSHE_DEFINES_SVH
`define MSHE_DEFINES_SVH

// Register byte offsets on the APB
`define MSHE_ADDR_STATUS     12'h000
`define MSHE_ADDR_INT_STATUS 12'h004
`define MSHE_ADDR_INT_MASK   12'h008
`define MSHE_ADDR_HALT       12'h00c

// Field positions in the status word
`define MSHE_IDLE_BIT        31
`define MSHE_TX_CODE_LSB     20
`define MSHE_TX_CH_LSB       16
`define MSHE_RX_CODE_LSB     12
`define MSHE_RX_CH_LSB       8

// Interrupt status and mask bit positions
`define MSHE_INT_TX_BIT      0
`define MSHE_INT_RX_BIT      1

// Host error codes
`define MSHE_ERR_NONE        4'h0
`define MSHE_ERR_SOP         4'h1
`define MSHE_ERR_OWN         4'h2
`define MSHE_ERR_NEXT_PTR    4'h3
`define MSHE_ERR_BUF_PTR     4'h4
`define MSHE_ERR_BUF_LEN     4'h5
`define MSHE_ERR_PKT_LEN     4'h6

// Reset values
`define MSHE_RST_CODE        4'h0
`define MSHE_RST_CH          3'h0
`define MSHE_RST_INT         2'h0
`define MSHE_RST_WORD        32'h0000_0000

`endif

// ===== logic/mshe_pkg.sv
package mshe_pkg;

  // Transmit descriptor check, one cycle per inspected buffer
  typedef struct packed {
    logic       valid;
    logic       first_buffer;
    logic       sop_flag;
    logic       own_flag;
    logic       next_ptr_zero;
    logic       eop_flag;
    logic       buf_ptr_zero;
    logic       buf_len_zero;
    logic       len_sum_short;
    logic       pkt_len_zero;
    logic [2:0] channel;
  } mshe_tx_desc_s;

  // Receive descriptor check, one cycle per inspected buffer
  typedef struct packed {
    logic       valid;
    logic       first_buffer;
    logic       own_flag;
    logic       buf_ptr_zero;
    logic [2:0] channel;
  } mshe_rx_desc_s;

  // Captured error of one direction
  typedef struct packed {
    logic       captured;
    logic [3:0] code;
    logic [2:0] channel;
  } mshe_err_s;

  // APB request and response
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mshe_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } mshe_apb_rsp_s;

endpackage : mshe_pkg

// ===== logic/mshe_tx_capture.sv
`timescale 1ns/1ps
`include "mshe_defines.svh"

module mshe_tx_capture (
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  input  wire mshe_pkg::mshe_tx_desc_s desc_i,
  input  wire logic                   clr_ch_i,
  output logic                        detect_o,
  output mshe_pkg::mshe_err_s         err_o
);
  import mshe_pkg::*;

  mshe_err_s  st;
  mshe_err_s  next_st;
  logic [3:0] code;

  // Classify the buffer in fixed priority order
  always_comb begin
    code = `MSHE_ERR_NONE;
    if (desc_i.first_buffer && !desc_i.sop_flag) begin
      code = `MSHE_ERR_SOP;
    end else if (desc_i.first_buffer && !desc_i.own_flag) begin
      code = `MSHE_ERR_OWN;
    end else if (desc_i.next_ptr_zero && !desc_i.eop_flag) begin
      code = `MSHE_ERR_NEXT_PTR;
    end else if (desc_i.buf_ptr_zero) begin
      code = `MSHE_ERR_BUF_PTR;
    end else if (desc_i.buf_len_zero) begin
      code = `MSHE_ERR_BUF_LEN;
    end else if (desc_i.len_sum_short) begin
      code = `MSHE_ERR_PKT_LEN;
    end
    // Zero packet length gives no code on its own
    detect_o = desc_i.valid && (code != `MSHE_ERR_NONE) && !st.captured;
    next_st = st;
    if (clr_ch_i) begin
      next_st.channel = `MSHE_RST_CH;
    end
    if (detect_o) begin
      next_st.captured = 1'b1;
      next_st.code     = code;
      next_st.channel  = desc_i.channel;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= '{1'b0, `MSHE_RST_CODE, `MSHE_RST_CH};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign err_o = st;

endmodule : mshe_tx_capture

// ===== logic/mshe_rx_capture.sv
`timescale 1ns/1ps
`include "mshe_defines.svh"

module mshe_rx_capture (
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  input  wire mshe_pkg::mshe_rx_desc_s desc_i,
  input  wire logic                   clr_ch_i,
  output logic                        detect_o,
  output mshe_pkg::mshe_err_s         err_o
);
  import mshe_pkg::*;

  mshe_err_s  st;
  mshe_err_s  next_st;
  logic [3:0] code;

  // Classify the receive buffer, ownership first
  always_comb begin
    code = `MSHE_ERR_NONE;
    if (desc_i.first_buffer && !desc_i.own_flag) begin
      code = `MSHE_ERR_OWN;
    end else if (desc_i.buf_ptr_zero) begin
      code = `MSHE_ERR_BUF_PTR;
    end
    detect_o = desc_i.valid && (code != `MSHE_ERR_NONE) && !st.captured;
    next_st = st;
    if (clr_ch_i) begin
      next_st.channel = `MSHE_RST_CH;
    end
    if (detect_o) begin
      next_st.captured = 1'b1;
      next_st.code     = code;
      next_st.channel  = desc_i.channel;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= '{1'b0, `MSHE_RST_CODE, `MSHE_RST_CH};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign err_o = st;

endmodule : mshe_rx_capture

// ===== verification/mshe_status_props.sv
`timescale 1ns/1ps
module mshe_status_props (
  input wire logic                    ref_clk_i,
  input wire logic                    rst_i,
  input wire logic                    ce_i,
  input wire logic                    mac_busy_i,
  input wire mshe_pkg::mshe_tx_desc_s tx_desc_i,
  input wire mshe_pkg::mshe_rx_desc_s rx_desc_i,
  input wire mshe_pkg::mshe_apb_req_s apb_req_i,
  input wire mshe_pkg::mshe_apb_rsp_s apb_rsp_o,
  input wire logic                    irq_o,
  input wire logic                    dma_halt_o
);
  import mshe_pkg::*;
  logic tx_err, rx_err, setup;
  // Descriptor faults that must raise a host error
  assign tx_err = tx_desc_i.valid && (tx_desc_i.first_buffer &&
    !(tx_desc_i.sop_flag && tx_desc_i.own_flag) || tx_desc_i.next_ptr_zero
    && !tx_desc_i.eop_flag || tx_desc_i.buf_ptr_zero ||
    tx_desc_i.buf_len_zero || tx_desc_i.len_sum_short);
  assign rx_err = rx_desc_i.valid && (rx_desc_i.first_buffer &&
    !rx_desc_i.own_flag || rx_desc_i.buf_ptr_zero);
  assign setup = ce_i && apb_req_i.psel && !apb_req_i.penable;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  chk_idle_bit:
  assert property (setup && apb_req_i.paddr == 12'h000 && $past(ce_i) &&
    !$past(rst_i) |=> apb_rsp_o.prdata[31] == !$past(mac_busy_i, 2))
    else $error("idle bit wrong");
  chk_rsvd_zero:
  assert property (apb_rsp_o.pready && apb_req_i.paddr == 12'h000 |->
    (apb_rsp_o.prdata & 32'h7f08_08ff) == 32'h0) else $error("reserved set");
  chk_err_halts:
  assert property (ce_i && (tx_err || rx_err) |=> dma_halt_o)
    else $error("error not captured");
  chk_quiet_ok:
  assert property (ce_i && !tx_err && !rx_err && !dma_halt_o |=> !dma_halt_o)
    else $error("halt without fault");
  chk_halt_sticky:
  assert property (dma_halt_o |=> dma_halt_o) else $error("halt dropped");
  chk_irq_cause:
  assert property (irq_o |-> dma_halt_o) else $error("irq without error");
  chk_bad_addr:
  assert property (setup && (apb_req_i.paddr > 12'h00c ||
    apb_req_i.paddr[1:0] != 2'h0) |=> apb_rsp_o.pready && apb_rsp_o.pslverr)
    else $error("unmapped not refused");
  chk_rdata_idle:
  assert property (!apb_rsp_o.pready |-> apb_rsp_o.prdata == 32'h0)
    else $error("read data outside access");
  cover property ($rose(dma_halt_o));
  cover property ($rose(irq_o));
  cover property (apb_rsp_o.pslverr);
  cover property (setup && apb_req_i.paddr == 12'h000);
endmodule : mshe_status_props

bind mshe_status mshe_status_props u_props (.ref_clk_i(ref_clk_i),
  .rst_i(rst_i), .ce_i(ce_i), .mac_busy_i(mac_busy_i),
  .tx_desc_i(tx_desc_i), .rx_desc_i(rx_desc_i), .apb_req_i(apb_req_i),
  .apb_rsp_o(apb_rsp_o), .irq_o(irq_o), .dma_halt_o(dma_halt_o));

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
  import mshe_pkg::*;
  typedef struct packed {
    logic [12:0] tx;
    logic [6:0]  rx;
    logic [31:0] word;
  } mshe_row_s;
  logic          ref_clk_i = 0, rst_i = 1, ce_i = 1, mac_busy_i = 0;
  logic          irq_o, dma_halt_o, err;
  logic [31:0]   rd;
  int            miscompares = 0, num_checks = 0, cycles = 0;
  mshe_tx_desc_s tx_desc_i = '0;
  mshe_rx_desc_s rx_desc_i = '0;
  mshe_apb_req_s apb_req_i = '0;
  mshe_apb_rsp_s apb_rsp_o;
  // Descriptor stimulus beside the status word it must leave
  mshe_row_s rows [9] = '{'{13'h1a85, 7'h0, 32'h8015_0000},
    '{13'h1c87, 7'h0, 32'h8027_0000}, '{13'h1700, 7'h0, 32'h8030_0000},
    '{13'h1ef2, 7'h0, 32'h8042_0000}, '{13'h1eb3, 7'h0, 32'h8053_0000},
    '{13'h1e96, 7'h0, 32'h8066_0000}, '{13'h1e89, 7'h0, 32'h8000_0000},
    '{13'h0, 7'h64, 32'h8000_2400}, '{13'h0, 7'h7b, 32'h8000_4300}};

  mshe_status u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .mac_busy_i(mac_busy_i), .tx_desc_i(tx_desc_i), .rx_desc_i(rx_desc_i),
    .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .irq_o(irq_o),
    .dma_halt_o(dma_halt_o));

  // Clock and hang guard
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles > 4000) begin
      miscompares++;
      results();
    end
  end

  task automatic results();
    $display("Checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // One APB transfer, then settle time for registered outputs
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    apb_req_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk_i);
    apb_req_i.penable <= 1'b1;
    // Ends on pready; with no timeout of its own, a missing pready runs into the bench timeout
    do begin
      @(posedge ref_clk_i);
    end while (apb_rsp_o.pready !== 1'b1);
    rd = apb_rsp_o.prdata;
    err = apb_rsp_o.pslverr;
    apb_req_i <= '0;
    repeat (2) @(posedge ref_clk_i);
  endtask : apb

  task automatic desc(input logic [12:0] t, input logic [6:0] r);
    tx_desc_i <= t;
    rx_desc_i <= r;
    @(posedge ref_clk_i);
    tx_desc_i <= '0;
    rx_desc_i <= '0;
    repeat (2) @(posedge ref_clk_i);
  endtask : desc

  task automatic rst_dut();
    rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : rst_dut

  initial begin
    logic h;
    foreach (rows[i]) begin
      rst_dut();
      h = |{rows[i].word[23:20], rows[i].word[15:12]};
      apb(1'b1, 12'h008, 32'h3);
      desc(rows[i].tx, rows[i].rx);
      `CHK("halt", h, dma_halt_o)
      `CHK("irq", h, irq_o)
      apb(1'b0, 12'h000, 32'h0);
      `CHK("status", rows[i].word, rd)
      apb(1'b0, 12'h000, 32'h0);
      `CHK("chan clear", rows[i].word & 32'hfff8_f8ff, rd)
      apb(1'b0, 12'h004, 32'h0);
      `CHK("pending", {30'h0, |rows[i].word[15:12], |rows[i].word[23:20]}, rd)
      apb(1'b1, 12'h004, 32'h3);
      `CHK("irq clear", 1'b0, irq_o)
      `CHK("halt held", h, dma_halt_o)
    end
    // Busy MAC, masked interrupt, second error ignored, status writes
    rst_dut();
    mac_busy_i <= 1'b1;
    // Clock enable low: a fault must leave no trace
    ce_i <= 1'b0;
    desc(13'h1e96, 7'h7b);
    `CHK("frozen halt", 1'b0, dma_halt_o)
    ce_i <= 1'b1;
    desc(13'h1a85, 7'h0);
    desc(13'h1c87, 7'h64);
    `CHK("masked irq", 1'b0, irq_o)
    apb(1'b1, 12'h000, 32'hffff_ffff);
    apb(1'b0, 12'h000, 32'h0);
    `CHK("busy word", 32'h0015_2400, rd)
    apb(1'b1, 12'h008, 32'h2);
    `CHK("rx irq", 1'b1, irq_o)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("halt reg", 32'h1, rd)
    results();
  end
endmodule : tb_top
